// ===== inc/pia_pkg.sv
// Shared constants and types for the prioritised interrupt acceptance block
package pia_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Source layout: three serial channels of four sources each
  localparam int PIA_NSRC     = 12;
  localparam int PIA_GRP_SIZE = 4;
  localparam int PIA_NGRP     = 3;
  localparam int PIA_IDX_W    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Vector numbers and table offsets
  localparam logic [7:0]  PIA_SER_VEC_FIRST = 8'h98;    // Vector 152
  localparam logic [7:0]  PIA_SER_VEC_LAST  = 8'hA3;    // Vector 163
  localparam logic [7:0]  PIA_RSV_VEC_FIRST = 8'hA4;    // Vector 164
  localparam logic [7:0]  PIA_RSV_VEC_LAST  = 8'hFF;    // Vector 255
  localparam logic [15:0] PIA_SER_OFF_FIRST = 16'h0260;
  localparam logic [15:0] PIA_RSV_OFF_LAST  = 16'h03FC;
  localparam logic [5:0]  PIA_OFF_PAD       = 6'h00;
  localparam logic [1:0]  PIA_OFF_SHIFT     = 2'h0;

  // Vectors of the non-maskable and sleep requests; values are arbitrary
  localparam logic [7:0]  PIA_NMI_VEC_DEF   = 8'h07;
  localparam logic [7:0]  PIA_SLEEP_VEC_DEF = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Levels
  localparam logic [2:0]  PIA_LEVEL_MAX     = 3'h7;
  localparam logic [2:0]  PIA_LEVEL_NONE    = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    PIA_MODE0 = 2'b00,
    PIA_MODE2 = 2'b10
  } pia_mode_t;

  typedef enum logic [1:0] {
    PIA_KIND_NONE  = 2'b00,
    PIA_KIND_NMI   = 2'b01,
    PIA_KIND_SLEEP = 2'b10,
    PIA_KIND_SRC   = 2'b11
  } pia_kind_t;

  typedef struct packed {
    logic                 valid;
    logic [7:0]           vec;
    logic [15:0]          offset;
    logic [2:0]           level;
    logic                 nonmask;
  } pia_req_t;

  typedef struct packed {
    pia_mode_t            mode;
    pia_req_t             req;
    pia_kind_t            kind;
    logic [PIA_IDX_W-1:0] idx;
  } pia_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Table offset is four bytes per vector
  function automatic logic [15:0] pia_vec_offset(input logic [7:0] vec);
    return {PIA_OFF_PAD, vec, PIA_OFF_SHIFT};
  endfunction

  // Vector of a serial source by its index
  function automatic logic [7:0] pia_src_vec(input logic [PIA_IDX_W-1:0] i);
    return PIA_SER_VEC_FIRST + {4'h0, i};
  endfunction

endpackage

// ===== core/pia_prio_pick.sv
// Priority pick among pending maskable sources
`timescale 1ns/1ps
module pia_prio_pick #(
  parameter int NSRC  = pia_pkg::PIA_NSRC,
  parameter int NGRP  = pia_pkg::PIA_NGRP,
  parameter int GSIZE = pia_pkg::PIA_GRP_SIZE
) (
  // Pending sources and per-group levels
  input  wire logic [NSRC-1:0]                pending,
  input  wire logic [NGRP-1:0][2:0]           grp_level,
  input  wire logic                           use_levels,
  // Winner
  output logic                                found,
  output logic [pia_pkg::PIA_IDX_W-1:0]       idx,
  output logic [2:0]                          level
);

  logic [2:0] lv;

  ////////////////////////////////////////////////////////////////////////////
  // Scan from the earliest source; only a strictly higher level displaces,
  // so equal levels fall back to the default ordering
  always_comb begin
    found = 1'b0;
    idx   = '0;
    level = pia_pkg::PIA_LEVEL_NONE;
    lv    = pia_pkg::PIA_LEVEL_NONE;
    for (int i = 0; i < NSRC; i++) begin
      lv = use_levels ? grp_level[i / GSIZE] : pia_pkg::PIA_LEVEL_NONE;
      if (pending[i] && (!found || lv > level)) begin
        found = 1'b1;
        idx   = pia_pkg::PIA_IDX_W'(i);
        level = lv;
      end
    end
  end

endmodule

// ===== core/pia_ctrl.sv
// Prioritised interrupt acceptance controller, top level
//
// Overview of operation
// - Two control modes exist, 0 and 2, with different acceptance.
// - Mode comes from a software-written mode selection setting.
// - Mode 0 uses fixed default ordering; priority fields are ignored.
// - Mode 2 gives each maskable source one of eight levels from its field.
// - A source requests only while its enable bit is 1.
// - Mode 0: global mask 1 holds maskable requests; 0 lets them through.
// - Mode 0: only the highest-priority active request goes to the CPU.
// - Mode 2: highest level wins; ties go to default ordering.
// - Mode 2: winner accepted only if its level exceeds the mask level.
// - Non-maskable and sleep requests skip the mask check in both modes.
// - Controller supplies the vector; CPU fetches and jumps to handler.
// - Serial sources occupy vectors 152 to 163, offsets from 0x0260.
// - Vectors 164 to 255 are reserved; last offset is 0x03FC.
`timescale 1ns/1ps
module pia_ctrl #(
  parameter int         NSRC      = pia_pkg::PIA_NSRC,
  parameter int         NGRP      = pia_pkg::PIA_NGRP,
  parameter int         GSIZE     = pia_pkg::PIA_GRP_SIZE,
  parameter logic [7:0] NMI_VEC   = pia_pkg::PIA_NMI_VEC_DEF,
  parameter logic [7:0] SLEEP_VEC = pia_pkg::PIA_SLEEP_VEC_DEF
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // Mode selection setting
  input  wire logic                       mode_wr,
  input  wire logic [1:0]                 mode_wr_data,
  output pia_pkg::pia_mode_t              mode_now,
  // Priority fields, one per serial channel of four sources
  input  wire logic [NGRP-1:0][2:0]       source_priority_field,
  // Sources
  input  wire logic [NSRC-1:0]            src_req,
  input  wire logic [NSRC-1:0]            src_enable,
  input  wire logic                       nmi_req,
  input  wire logic                       sleep_req,
  output logic [NSRC-1:0]                 src_pending,
  // Acceptance strobes back to the sources
  output logic [NSRC-1:0]                 ack_src,
  output logic                            ack_nmi,
  output logic                            ack_sleep,
  // CPU side
  input  wire logic                       cpu_global_mask,
  input  wire logic [2:0]                 mask_level_field,
  input  wire logic                       cpu_ack,
  output logic                            irq_req,
  output logic [7:0]                      irq_vector,
  output logic [15:0]                     irq_offset,
  output logic [2:0]                      irq_level,
  output logic                            irq_nonmask
);

  pia_pkg::pia_state_t                 st;
  pia_pkg::pia_state_t                 next_st;
  logic [NSRC-1:0]                     in_table;
  logic                                found;
  logic [pia_pkg::PIA_IDX_W-1:0]       win_idx;
  logic [2:0]                          win_level;
  logic                                use_levels;
  logic                                maskable_ok;
  logic                                taken;

  ////////////////////////////////////////////////////////////////////////////
  // Only sources whose vector lands below the reserved range can be mapped
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      in_table[i] = pia_pkg::pia_src_vec(pia_pkg::PIA_IDX_W'(i))
                    <= pia_pkg::PIA_SER_VEC_LAST;
    end
  end

  // Pending is the live request gated by its enable; it is never latched
  // here, so only the source itself or its enable bit can withdraw it
  assign src_pending = src_req & src_enable & in_table;

  assign use_levels = (st.mode == pia_pkg::PIA_MODE2);

  pia_prio_pick #(
    .NSRC  (NSRC),
    .NGRP  (NGRP),
    .GSIZE (GSIZE)
  ) u_pick (
    .pending    (src_pending),
    .grp_level  (source_priority_field),
    .use_levels (use_levels),
    .found      (found),
    .idx        (win_idx),
    .level      (win_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask check applies to the chosen request only
  always_comb begin
    if (st.mode == pia_pkg::PIA_MODE0) begin
      maskable_ok = !cpu_global_mask;
    end else begin
      maskable_ok = win_level > mask_level_field;
    end
  end

  // The CPU takes the presented request when it is ready to handle it
  assign taken = cpu_ack && st.req.valid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Other codes are not a mode and are ignored
    if (mode_wr && (mode_wr_data == pia_pkg::PIA_MODE0 ||
                    mode_wr_data == pia_pkg::PIA_MODE2)) begin
      next_st.mode = pia_pkg::pia_mode_t'(mode_wr_data);
    end
    next_st.req.valid   = 1'b0;
    next_st.req.vec     = st.req.vec;
    next_st.req.offset  = st.req.offset;
    next_st.req.level   = st.req.level;
    next_st.req.nonmask = 1'b0;
    next_st.kind        = pia_pkg::PIA_KIND_NONE;
    // One idle cycle after acceptance lets the source withdraw first
    if (taken) begin
      next_st.req.valid = 1'b0;
    end else if (nmi_req) begin
      next_st.req.valid   = 1'b1;
      next_st.req.vec     = NMI_VEC;
      next_st.req.offset  = pia_pkg::pia_vec_offset(NMI_VEC);
      next_st.req.level   = pia_pkg::PIA_LEVEL_MAX;
      next_st.req.nonmask = 1'b1;
      next_st.kind        = pia_pkg::PIA_KIND_NMI;
    end else if (sleep_req) begin
      next_st.req.valid   = 1'b1;
      next_st.req.vec     = SLEEP_VEC;
      next_st.req.offset  = pia_pkg::pia_vec_offset(SLEEP_VEC);
      next_st.req.level   = pia_pkg::PIA_LEVEL_MAX;
      next_st.req.nonmask = 1'b1;
      next_st.kind        = pia_pkg::PIA_KIND_SLEEP;
    end else if (found && maskable_ok) begin
      next_st.req.valid   = 1'b1;
      next_st.req.vec     = pia_pkg::pia_src_vec(win_idx);
      next_st.req.offset  =
        pia_pkg::pia_vec_offset(pia_pkg::pia_src_vec(win_idx));
      next_st.req.level   = win_level;
      next_st.kind        = pia_pkg::PIA_KIND_SRC;
      next_st.idx         = win_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; mode 0 after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.mode        <= pia_pkg::PIA_MODE0;
      st.req.valid   <= 1'b0;
      st.req.vec     <= pia_pkg::PIA_SER_VEC_FIRST;
      st.req.offset  <= pia_pkg::PIA_SER_OFF_FIRST;
      st.req.level   <= pia_pkg::PIA_LEVEL_NONE;
      st.req.nonmask <= 1'b0;
      st.kind        <= pia_pkg::PIA_KIND_NONE;
      st.idx         <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance strobes are combinational so the source clears in time
  always_comb begin
    ack_src = '0;
    if (taken && st.kind == pia_pkg::PIA_KIND_SRC) begin
      ack_src[st.idx] = 1'b1;
    end
  end
  assign ack_nmi   = taken && (st.kind == pia_pkg::PIA_KIND_NMI);
  assign ack_sleep = taken && (st.kind == pia_pkg::PIA_KIND_SLEEP);

  // Outputs to the CPU, all from flip-flops
  assign mode_now    = st.mode;
  assign irq_req     = st.req.valid;
  assign irq_vector  = st.req.vec;
  assign irq_offset  = st.req.offset;
  assign irq_level   = st.req.level;
  assign irq_nonmask = st.req.nonmask;

endmodule

// ===== verif/pia_ctrl_sva.sv
// Port assertions for the interrupt acceptance controller
`timescale 1ns/1ps
module pia_ctrl_sva #(
  parameter int         NSRC    = 12,
  parameter logic [7:0] NMI_VEC = 8'h07
) (
  // Clock, reset and mode
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               mode_wr,
  input wire logic [1:0]         mode_wr_data,
  input wire pia_pkg::pia_mode_t mode_now,
  // Sources and acks
  input wire logic [NSRC-1:0]    src_req,
  input wire logic [NSRC-1:0]    src_enable,
  input wire logic [NSRC-1:0]    src_pending,
  input wire logic [NSRC-1:0]    ack_src,
  input wire logic               nmi_req,
  input wire logic               ack_nmi,
  input wire logic               ack_sleep,
  // CPU side
  input wire logic               cpu_global_mask,
  input wire logic [2:0]         mask_level_field,
  input wire logic               cpu_ack,
  input wire logic               irq_req,
  input wire logic [7:0]         irq_vector,
  input wire logic [15:0]        irq_offset,
  input wire logic [2:0]         irq_level,
  input wire logic               irq_nonmask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////
  // Each check but a_offset_x4 and a_vec_range ties an output to the inputs of the cycle that caused it
  a_pend_match: assert property (
    src_pending == (src_req & src_enable))
    else $error("pending differs from enabled requests");
  a_ack_cause: assert property (
    |{ack_src, ack_nmi, ack_sleep} |-> cpu_ack && irq_req)
    else $error("ack without an accepted request");
  a_offset_x4: assert property (
    irq_req |-> irq_offset == {6'h00, irq_vector, 2'h0})
    else $error("offset is not four times the vector");
  a_vec_range: assert property (
    irq_req && !irq_nonmask |-> irq_vector inside {[8'h98:8'hA3]})
    else $error("maskable vector outside serial range");
  a_mode0_mask: assert property (
    mode_now == pia_pkg::PIA_MODE0 && !mode_wr && cpu_global_mask
    |=> !(irq_req && !irq_nonmask))
    else $error("maskable request passed a set mask");
  a_mode2_level: assert property (
    irq_req && !irq_nonmask && mode_now == pia_pkg::PIA_MODE2 &&
    $past(mode_now) == pia_pkg::PIA_MODE2
    |-> irq_level > $past(mask_level_field))
    else $error("request not above mask level");
  a_nmi_wins: assert property (
    nmi_req && !cpu_ack
    |=> irq_req && irq_nonmask && irq_vector == NMI_VEC)
    else $error("non-maskable request not presented");
  a_mode_two: assert property (
    mode_wr && mode_wr_data == 2'b10 |=> mode_now == pia_pkg::PIA_MODE2)
    else $error("mode 2 write not taken");
  a_mode_bad: assert property (
    mode_wr && mode_wr_data[0] |=> $stable(mode_now))
    else $error("illegal mode code changed mode");
endmodule
bind pia_ctrl pia_ctrl_sva #(.NSRC(NSRC), .NMI_VEC(NMI_VEC)) pia_ctrl_sva_inst (
  .clk, .rstn, .mode_wr, .mode_wr_data, .mode_now, .src_req, .src_enable,
  .src_pending, .ack_src, .nmi_req, .ack_nmi, .ack_sleep, .cpu_global_mask,
  .mask_level_field, .cpu_ack, .irq_req, .irq_vector, .irq_offset,
  .irq_level, .irq_nonmask);

// ===== verif/pia_cpu_model.sv
// Behavioural CPU that accepts presented requests and updates its masks
`timescale 1ns/1ps
module pia_cpu_model (
  // Clock, reset, acceptance enable and mode
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic       mode2,
  // Software write of both masks
  input  wire logic       sw_wr,
  input  wire logic       sw_gm,
  input  wire logic [2:0] sw_ml,
  // Controller side
  input  wire logic       irq_req,
  input  wire logic [2:0] irq_level,
  input  wire logic       irq_nonmask,
  output logic            cpu_ack,
  output logic            gm,
  output logic [2:0]      ml
);
  // Words saved on the stack and the trace bit of the extended status
  logic [1:0] stacked;
  logic       trace;
  // Ack waits a cycle, as if finishing the current instruction
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ack <= 1'b0;
      gm <= 1'b0;
      ml <= 3'h0;
      stacked <= 2'h0;
      trace <= 1'b1;
    end else begin
      cpu_ack <= irq_req & go & !cpu_ack;
      if (sw_wr) begin
        gm <= sw_gm;
        ml <= sw_ml;
      end else if (cpu_ack && irq_req) begin
        // Both masks load; each mode only looks at its own
        gm <= 1'b1;
        ml <= irq_nonmask ? 3'h7 : irq_level;
        stacked <= mode2 ? 2'h3 : 2'h2;
        if (mode2) begin
          trace <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== verif/tb_pia_ctrl.sv
// Self-checking bench for the interrupt acceptance controller
`timescale 1ns/1ps
module tb_pia_ctrl;
  logic               clk, rstn, mode_wr, nmi_req, go;
  logic               sleep_req, sw_wr, sw_gm;
  logic [2:0]         sw_ml;
  logic [1:0]         mode_wr_data;
  logic [2:0][2:0]    source_priority_field;
  logic [11:0]        src_req, src_enable, src_pending, ack_src;
  logic               ack_nmi, ack_sleep, cpu_ack, cpu_global_mask;
  logic               irq_req, irq_nonmask;
  logic [2:0]         mask_level_field, irq_level;
  logic [7:0]         irq_vector;
  logic [15:0]        irq_offset;
  pia_pkg::pia_mode_t mode_now;
  int                 failures, n_checks;

  pia_ctrl pia_ctrl_inst (
    .clk, .rstn, .mode_wr, .mode_wr_data, .mode_now, .source_priority_field,
    .src_req, .src_enable, .nmi_req, .sleep_req, .src_pending,
    .ack_src, .ack_nmi, .ack_sleep, .cpu_global_mask, .mask_level_field,
    .cpu_ack, .irq_req, .irq_vector, .irq_offset, .irq_level, .irq_nonmask);
  pia_cpu_model pia_cpu_model_inst (
    .clk, .rstn, .go, .mode2(mode_now == pia_pkg::PIA_MODE2),
    .sw_wr, .sw_gm, .sw_ml, .irq_req, .irq_level, .irq_nonmask, .cpu_ack,
    .gm(cpu_global_mask), .ml(mask_level_field));

  // Clock at 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Sources withdraw on acceptance; the bench never drives them then
  always @(posedge clk) begin
    if (|{ack_src, ack_nmi, ack_sleep}) begin
      src_req <= src_req & ~ack_src;
      nmi_req <= nmi_req & ~ack_nmi;
      sleep_req <= sleep_req & ~ack_sleep;
    end
  end
  // Software write of the CPU masks, one cycle
  task automatic set_mask(input logic g, input logic [2:0] l);
    sw_gm <= g;
    sw_ml <= l;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Registered answer lands one edge later; look a cycle after that
  task automatic show(input logic v, input logic [7:0] vec,
                      input logic [2:0] lv);
    repeat (2) @(posedge clk);
    #1 chk("irq_req", {15'h0, irq_req}, {15'h0, v});
    if (v) begin
      chk("vector", {8'h0, irq_vector}, {8'h0, vec});
      chk("offset", irq_offset, {8'h0, vec} * 16'h4);
      chk("level", {13'h0, irq_level}, {13'h0, lv});
    end
    @(posedge clk);
  endtask
  // One acceptance by the CPU model; acks are seen while it is high
  task automatic take(input logic [13:0] exp);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1 chk("ack", {2'h0, ack_sleep, ack_nmi, ack_src}, {2'h0, exp});
    repeat (2) @(posedge clk);
  endtask
  task automatic set_mode(input logic [1:0] d, input logic [1:0] exp);
    mode_wr <= 1'b1;
    mode_wr_data <= d;
    @(posedge clk);
    mode_wr <= 1'b0;
    @(posedge clk);
    #1 chk("mode", {14'h0, mode_now}, {14'h0, exp});
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rstn, mode_wr, nmi_req, go, mode_wr_data, src_req} = '0;
    {sleep_req, sw_wr, sw_gm, sw_ml} = '0;
    src_enable = 12'hFFF;
    source_priority_field = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Every serial source alone gives its own vector and offset
    for (int i = 0; i < 12; i++) begin
      set_mask(1'b0, 3'h0);
      src_req <= 12'h001 << i;
      show(1'b1, 8'h98 + 8'(i), 3'h0);
      take(13'h001 << i);
    end
    $display("vector table test done");
    // Fields ignored in mode 0; the loser waits behind the CPU's mask
    set_mask(1'b0, 3'h0);
    source_priority_field <= {3'h1, 3'h7, 3'h1};
    src_req <= 12'h120;
    show(1'b1, 8'h9D, 3'h0);
    take(13'h020);
    show(1'b0, 8'h00, 3'h0);
    chk("pending", src_pending, 12'h100);
    set_mask(1'b0, 3'h0);
    src_enable <= 12'hEFF;
    show(1'b0, 8'h00, 3'h0);
    src_enable <= 12'hFFF;
    show(1'b1, 8'hA0, 3'h0);
    take(13'h100);
    chk("stacked", {14'h0, pia_cpu_model_inst.stacked}, 16'h2);
    $display("mode 0 test done");
    // Mode 2: levels, ties, mask level and non-maskable bypass
    set_mode(2'b01, 2'b00);
    set_mode(2'b10, 2'b10);
    source_priority_field <= {3'h5, 3'h5, 3'h2};
    set_mask(1'b0, 3'h5);
    src_req <= 12'h241;
    show(1'b0, 8'h00, 3'h0);
    set_mask(1'b0, 3'h4);
    show(1'b1, 8'h9E, 3'h5);
    take(13'h040);
    chk("stacked", {14'h0, pia_cpu_model_inst.stacked}, 16'h3);
    chk("trace", {15'h0, pia_cpu_model_inst.trace}, 16'h0);
    show(1'b0, 8'h00, 3'h0);
    set_mask(1'b0, 3'h1);
    show(1'b1, 8'hA1, 3'h5);
    take(13'h200);
    nmi_req <= 1'b1;
    show(1'b1, 8'h07, 3'h7);
    chk("nonmask", {15'h0, irq_nonmask}, 16'h1);
    take(13'h1000);
    show(1'b0, 8'h00, 3'h0);
    sleep_req <= 1'b1;
    show(1'b1, 8'h08, 3'h7);
    take(14'h2000);
    $display("mode 2 test done");
    print_verdict();
  end
  // Watchdog: the run needs about 150 cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
